/* File: design/owc_osc_control.sv */
// owc_osc_control: oscillation control register with oscillator and
// pll enables, warm-up timer control, pll source select, interrupt.
// assumes a plain register port master on clk; oscillator pins are
// asynchronous and are sampled through three flip-flops.
//
// Function
// - write one to start launches warm-up
// - running flag reads one while counting
// - pll enable bit stops or runs pll
// - pll stopped after reset, software enables
// - source select picks fast or slow oscillator
// - time code sets length, resets to one
// - fast oscillator enable, resets to one
// - slow oscillator enable, resets to one
module owc_osc_control
  import owc_pkg::*;
#(
  parameter int SCALE_DOWN = 0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdData,
  input wire logic fastOscClk,
  input wire logic slowOscClk,
  output logic fastOscEnable,
  output logic slowOscEnable,
  output logic pllEnable,
  output logic pllSourceSelect,
  output logic irq
);

  // control register fields
  logic pllEnReg;
  logic srcReg;
  logic [2:0] timeReg;
  logic fastEnReg;
  logic slowEnReg;
  logic pllSrcReg;
  logic doneStatReg;
  logic doneMaskReg;
  logic [31:0] rdDataReg;
  logic [31:0] rdNext;

  // decode
  logic wrCtrl;
  logic wrPllSel;
  logic wrStat;
  logic wrMask;
  logic startPulse;
  logic startSrc;
  logic [2:0] startTime;

  // timer side
  logic fastTick;
  logic slowTick;
  logic running;
  logic warmDone;

  assign wrCtrl = wrEn && (addr == OWC_OFF_CTRL);
  assign wrPllSel = wrEn && (addr == OWC_OFF_PLL_SOURCE_SELECT);
  assign wrStat = wrEn && (addr == OWC_OFF_STAT);
  assign wrMask = wrEn && (addr == OWC_OFF_MASK);

  // only a written one starts; a zero leaves the timer alone
  assign startPulse = wrCtrl && wrData[OWC_BIT_START];

  // a start written together with new fields uses the new fields
  assign startSrc = wrData[OWC_BIT_SRC];
  assign startTime = wrData[OWC_BIT_TIME +: 3];

  // oscillator pins into the clock domain
  owc_pin_edge u_fast_edge (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(fastOscClk),
    .rise(fastTick)
  );

  owc_pin_edge u_slow_edge (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(slowOscClk),
    .rise(slowTick)
  );

  // warm-up timer; source and length chosen at start
  owc_warmup_counter #(
    .SCALE_DOWN(SCALE_DOWN)
  ) u_counter (
    .clk(clk),
    .rst_n(rst_n),
    .start(startPulse),
    .srcSel(startSrc),
    .timeCode(startTime),
    .fastTick(fastTick),
    .slowTick(slowTick),
    .running(running),
    .done(warmDone)
  );

  // pll enable; cleared at reset so the pll starts stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pllEnReg <= OWC_PLLEN_RST;
    end else if (wrCtrl) begin
      pllEnReg <= wrData[OWC_BIT_PLLEN];
    end
  end

  // warm-up source and length fields
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srcReg <= OWC_SRC_RST;
      timeReg <= OWC_TIME_RST;
    end else if (wrCtrl) begin
      srcReg <= wrData[OWC_BIT_SRC];
      timeReg <= wrData[OWC_BIT_TIME +: 3];
    end
  end

  // oscillator enables run from reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fastEnReg <= OWC_FASTEN_RST;
      slowEnReg <= OWC_SLOWEN_RST;
    end else if (wrCtrl) begin
      fastEnReg <= wrData[OWC_BIT_FASTEN];
      slowEnReg <= wrData[OWC_BIT_SLOWEN];
    end
  end

  // pll source select; software deselects it before stopping the pll
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pllSrcReg <= OWC_PLLSRC_RST;
    end else if (wrPllSel) begin
      pllSrcReg <= wrData[OWC_BIT_PLLSRC];
    end
  end

  // sticky done flag: a completion in the clear cycle is kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      doneStatReg <= 1'b0;
    end else if (warmDone) begin
      doneStatReg <= 1'b1;
    end else if (wrStat && wrData[OWC_BIT_DONE]) begin
      doneStatReg <= 1'b0;
    end
  end

  // interrupt mask
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      doneMaskReg <= 1'b0;
    end else if (wrMask) begin
      doneMaskReg <= wrData[OWC_BIT_DONE];
    end
  end

  // read mux; start bit and unused bits always read zero
  always_comb begin
    rdNext = 32'h0000_0000;
    case (addr)
      OWC_OFF_CTRL: begin
        rdNext[OWC_BIT_START] = 1'b0;
        rdNext[OWC_BIT_RUN] = running;
        rdNext[OWC_BIT_PLLEN] = pllEnReg;
        rdNext[OWC_BIT_SRC] = srcReg;
        rdNext[OWC_BIT_TIME +: 3] = timeReg;
        rdNext[OWC_BIT_FASTEN] = fastEnReg;
        rdNext[OWC_BIT_SLOWEN] = slowEnReg;
      end
      OWC_OFF_PLL_SOURCE_SELECT: begin
        rdNext[OWC_BIT_PLLSRC] = pllSrcReg;
      end
      OWC_OFF_STAT: begin
        rdNext[OWC_BIT_DONE] = doneStatReg;
      end
      OWC_OFF_MASK: begin
        rdNext[OWC_BIT_DONE] = doneMaskReg;
      end
      default: begin
        rdNext = 32'h0000_0000;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdDataReg <= 32'h0000_0000;
    end else if (rdEn) begin
      rdDataReg <= rdNext;
    end else begin
      rdDataReg <= 32'h0000_0000;
    end
  end

  assign rdData = rdDataReg;
  assign fastOscEnable = fastEnReg;
  assign slowOscEnable = slowEnReg;
  assign pllEnable = pllEnReg;
  assign pllSourceSelect = pllSrcReg;
  // level interrupt while the unmasked done flag stands
  assign irq = doneStatReg && doneMaskReg;

  // helper: high only in the first cycle after reset release
  logic firstReg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      firstReg <= 1'b1;
    end else begin
      firstReg <= 1'b0;
    end
  end

  property p_start_runs;
    @(posedge clk) disable iff (!rst_n)
      (startPulse && (startTime != OWC_TIME_NONE)) |=> running;
  endproperty
  a_start_runs: assert property (p_start_runs)
    else $error("start with nonzero length did not set running");

  property p_zero_start;
    @(posedge clk) disable iff (!rst_n)
      (startPulse && (startTime == OWC_TIME_NONE))
        |=> (!running && warmDone) ##1 doneStatReg;
  endproperty
  a_zero_start: assert property (p_zero_start)
    else $error("zero length start did not complete at once");

  property p_start_reads_zero;
    @(posedge clk) disable iff (!rst_n)
      (rdEn && (addr == OWC_OFF_CTRL)) |=> (rdData[OWC_BIT_START] == 1'b0);
  endproperty
  a_start_reads_zero: assert property (p_start_reads_zero)
    else $error("start bit read back nonzero");

  property p_run_flag;
    @(posedge clk) disable iff (!rst_n)
      (rdEn && (addr == OWC_OFF_CTRL))
        |=> (rdData[OWC_BIT_RUN] == $past(running));
  endproperty
  a_run_flag: assert property (p_run_flag)
    else $error("running flag read does not match timer state");

  property p_pll_write;
    @(posedge clk) disable iff (!rst_n)
      wrCtrl |=> (pllEnable == $past(wrData[OWC_BIT_PLLEN]));
  endproperty
  a_pll_write: assert property (p_pll_write)
    else $error("pll enable did not follow write");

  property p_reset_values;
    @(posedge clk) disable iff (!rst_n)
      firstReg |-> (!pllEnable && fastOscEnable && slowOscEnable
        && !running && !irq);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("wrong output values after reset");

  property p_osc_enables;
    @(posedge clk) disable iff (!rst_n)
      wrCtrl |=> (fastOscEnable == $past(wrData[OWC_BIT_FASTEN]))
        && (slowOscEnable == $past(wrData[OWC_BIT_SLOWEN]));
  endproperty
  a_osc_enables: assert property (p_osc_enables)
    else $error("oscillator enables did not follow write");

  property p_unused_zero;
    @(posedge clk) disable iff (!rst_n)
      (rdEn && (addr == OWC_OFF_CTRL))
        |=> (rdData[31:10] == 22'h00_0000) && !rdData[7];
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused control bits read nonzero");

  property p_done_clears_run;
    @(posedge clk) disable iff (!rst_n)
      (warmDone && !$past(startPulse))
        |-> (!running && $past(running));
  endproperty
  a_done_clears_run: assert property (p_done_clears_run)
    else $error("running still set on completion");

  property p_done_sticky;
    @(posedge clk) disable iff (!rst_n)
      (warmDone || (doneStatReg && !(wrStat && wrData[OWC_BIT_DONE]))) |=> doneStatReg;
  endproperty
  a_done_sticky: assert property (p_done_sticky)
    else $error("completion flag lost");

  property p_irq_level;
    @(posedge clk) disable iff (!rst_n)
      (doneStatReg && doneMaskReg && !wrStat && !wrMask) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt dropped while unmasked flag set");

  // field writes land in the cycle after the strobe
  property p_fields_write;
    @(posedge clk) disable iff (!rst_n)
      wrCtrl |=> (srcReg == $past(wrData[OWC_BIT_SRC]))
        && (timeReg == $past(wrData[OWC_BIT_TIME +: 3]));
  endproperty
  a_fields_write: assert property (p_fields_write)
    else $error("warm-up source or length did not follow write");

  property p_pll_sel_write;
    @(posedge clk) disable iff (!rst_n)
      wrPllSel |=> (pllSourceSelect == $past(wrData[OWC_BIT_PLLSRC]));
  endproperty
  a_pll_sel_write: assert property (p_pll_sel_write)
    else $error("pll source select did not follow write");

  property p_mask_write;
    @(posedge clk) disable iff (!rst_n)
      wrMask |=> (doneMaskReg == $past(wrData[OWC_BIT_DONE]));
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("interrupt mask did not follow write");

  // a clear without a completion in the same cycle empties the flag
  property p_done_clear;
    @(posedge clk) disable iff (!rst_n)
      (wrStat && wrData[OWC_BIT_DONE] && !warmDone) |=> !doneStatReg;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("completion flag not cleared by write");

  // read data must not linger past its one cycle
  property p_rd_idle;
    @(posedge clk) disable iff (!rst_n)
      !rdEn |=> (rdData == 32'h0000_0000);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");

endmodule : owc_osc_control

/* File: design/owc_pkg.sv */
// owc_pkg: register map, field positions, reset values and types
// shared by the oscillation control block and its helpers.
// assumes one 40 MHz system clock and 32-bit register words.
package owc_pkg;

  // register byte offsets
  localparam logic [7:0] OWC_OFF_CTRL = 8'h00;
  localparam logic [7:0] OWC_OFF_PLL_SOURCE_SELECT = 8'h04;
  localparam logic [7:0] OWC_OFF_STAT = 8'h08;
  localparam logic [7:0] OWC_OFF_MASK = 8'h0C;

  // oscillation_control field positions
  localparam int OWC_BIT_START = 0;
  localparam int OWC_BIT_RUN = 1;
  localparam int OWC_BIT_PLLEN = 2;
  localparam int OWC_BIT_SRC = 3;
  localparam int OWC_BIT_TIME = 4;
  localparam int OWC_BIT_FASTEN = 8;
  localparam int OWC_BIT_SLOWEN = 9;

  // pll_selection_register and status field positions
  localparam int OWC_BIT_PLLSRC = 0;
  localparam int OWC_BIT_DONE = 0;

  // reset values
  localparam logic [2:0] OWC_TIME_RST = 3'h1;
  localparam logic OWC_PLLEN_RST = 1'b0;
  localparam logic OWC_FASTEN_RST = 1'b1;
  localparam logic OWC_SLOWEN_RST = 1'b1;
  localparam logic OWC_SRC_RST = 1'b0;
  localparam logic OWC_PLLSRC_RST = 1'b0;

  // timing: counter width covers the longest length, 2^18 periods
  localparam int OWC_CNT_W = 19;
  localparam logic [2:0] OWC_TIME_NONE = 3'h0;

  typedef enum logic [0:0] {
    OWC_IDLE = 1'b0,
    OWC_COUNT = 1'b1
  } owc_state_t;

  // period exponent per source and code; code 0 is never counted
  function automatic logic [4:0] owc_exponent(input logic slow, input logic [2:0] code);
    logic [4:0] c;
    c = {2'b00, code};
    if (!slow) begin
      owc_exponent = c + 5'h09;
    end else if (code <= 3'h3) begin
      owc_exponent = c + 5'h05;
    end else begin
      owc_exponent = c + 5'h0B;
    end
  endfunction : owc_exponent

endpackage : owc_pkg

/* File: design/owc_pin_edge.sv */
// owc_pin_edge: three-stage synchroniser for an oscillator pin,
// giving a one-cycle pulse on each filtered rising edge.
// assumes the pin toggles slower than half the system clock.
module owc_pin_edge
  import owc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pinIn,
  output logic rise
);

  logic s1Reg;
  logic s2Reg;
  logic s3Reg;
  logic levelReg;
  logic riseReg;

  // s1 feeds s2 only; a change counts when s2 and s3 agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1Reg <= 1'b0;
      s2Reg <= 1'b0;
      s3Reg <= 1'b0;
    end else begin
      s1Reg <= pinIn;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
    end
  end

  // filtered level and its rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      levelReg <= 1'b0;
      riseReg <= 1'b0;
    end else begin
      riseReg <= (s2Reg == s3Reg) && s2Reg && !levelReg;
      if (s2Reg == s3Reg) begin
        levelReg <= s2Reg;
      end
    end
  end

  assign rise = riseReg;

endmodule : owc_pin_edge

/* File: design/owc_warmup_counter.sv */
// owc_warmup_counter: counts periods of the chosen oscillator up to
// a power-of-two length and pulses done when the count is reached.
// assumes start is a one-cycle pulse and ticks are one-cycle pulses.
module owc_warmup_counter
  import owc_pkg::*;
#(
  parameter int SCALE_DOWN = 0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic srcSel,
  input wire logic [2:0] timeCode,
  input wire logic fastTick,
  input wire logic slowTick,
  output logic running,
  output logic done
);

  owc_state_t stateReg;
  logic srcReg;
  logic [OWC_CNT_W-1:0] cntReg;
  logic [OWC_CNT_W-1:0] lastReg;
  logic [4:0] expRaw;
  logic [4:0] expEff;
  logic tick;
  logic doneReg;

  // shortened exponent for simulation, never below one
  always_comb begin
    expRaw = owc_exponent(srcSel, timeCode);
    if (expRaw > 5'(SCALE_DOWN)) begin
      expEff = expRaw - 5'(SCALE_DOWN);
    end else begin
      expEff = 5'h01;
    end
  end

  // source latched at start so a later write cannot disturb a count
  assign tick = srcReg ? slowTick : fastTick;

  // restart wins over a count in progress
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= OWC_IDLE;
      srcReg <= 1'b0;
      cntReg <= '0;
      lastReg <= '0;
      doneReg <= 1'b0;
    end else begin
      doneReg <= 1'b0;
      if (start) begin
        srcReg <= srcSel;
        cntReg <= '0;
        lastReg <= (OWC_CNT_W'(1) << expEff) - OWC_CNT_W'(1);
        if (timeCode == OWC_TIME_NONE) begin
          stateReg <= OWC_IDLE;
          doneReg <= 1'b1;
        end else begin
          stateReg <= OWC_COUNT;
        end
      end else begin
        case (stateReg)
          OWC_COUNT: begin
            if (tick) begin
              if (cntReg == lastReg) begin
                stateReg <= OWC_IDLE;
                doneReg <= 1'b1;
              end else begin
                cntReg <= cntReg + OWC_CNT_W'(1);
              end
            end
          end
          default: begin
            stateReg <= OWC_IDLE;
          end
        endcase
      end
    end
  end

  assign running = (stateReg == OWC_COUNT);
  assign done = doneReg;

endmodule : owc_warmup_counter

/* File: testbench/test_owc_osc_control.sv */
// test_owc_osc_control: self-checking bench for the oscillation control block.
// assumes the register port and both oscillator pins are driven from here,
// with the warm-up lengths shortened through SCALE_DOWN.
module test_owc_osc_control
  import owc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SCALE = 9;
  logic clk, rst_n, wrEn, rdEn, fastOscClk, slowOscClk, srcNow, prevSel;
  logic [7:0] addr;
  logic [31:0] wrData, rdData;
  logic fastOscEnable, slowOscEnable, pllEnable, pllSourceSelect, irq;
  logic [3:0] pinCnt;
  int edgeCnt, errorCnt, nChecks;
  integer seed = 32'hc304_27df;

  owc_osc_control #(.SCALE_DOWN(SCALE)) DUT (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .fastOscClk(fastOscClk),
    .slowOscClk(slowOscClk), .fastOscEnable(fastOscEnable), .slowOscEnable(slowOscEnable),
    .pllEnable(pllEnable), .pllSourceSelect(pllSourceSelect), .irq(irq));

  // 25 ns clock
  always #12.5 clk = ~clk;

  // selected pin has period 8, the other runs twice as fast to expose a swap
  always @(posedge clk) begin
    pinCnt <= pinCnt + 4'h1;
    fastOscClk <= srcNow ? pinCnt[1] : pinCnt[2];
    slowOscClk <= srcNow ? pinCnt[2] : pinCnt[1];
    prevSel <= srcNow ? slowOscClk : fastOscClk;
    if ((srcNow ? slowOscClk : fastOscClk) && !prevSel) edgeCnt <= edgeCnt + 1;
  end

  task automatic reportAndStop();
    if (errorCnt == 0 && nChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : reportAndStop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wrData <= v;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 d = rdData;
  endtask : rd

  // expected period exponent, floored at one like the shortened counter
  function automatic int expOf(input logic src, input logic [2:0] code);
    int e;
    e = !src ? 9 + code : (code <= 3'h3 ? 5 + code : 11 + code);
    e = e - SCALE;
    return (e < 1) ? 1 : e;
  endfunction : expOf

  task automatic doReset();
    logic [31:0] d;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({fastOscEnable, slowOscEnable, pllEnable, pllSourceSelect, irq}, 5'b11000);
    rd(OWC_OFF_CTRL, d);
    chk(d, 32'h0000_0310);
  endtask : doReset

  // start a warm-up and count selected pin edges until the done interrupt
  task automatic warm(input logic src, input logic [2:0] code, input logic again);
    logic [31:0] d;
    int n, e, lim;
    n = (code == 3'h0) ? 0 : (1 << expOf(src, code));
    srcNow <= src;
    repeat (4) @(posedge clk);
    wr(OWC_OFF_CTRL, {22'h0, 2'b11, 1'b0, code, src, 3'b001});
    e = edgeCnt;
    if (again) begin
      repeat (24) @(posedge clk);
      wr(OWC_OFF_CTRL, {22'h0, 2'b11, 1'b0, code, src, 3'b001});
      e = edgeCnt;
    end
    rd(OWC_OFF_CTRL, d);
    chk(d[1:0], {code != 3'h0, 1'b0});
    chk(d[6:3], {code, src});
    lim = n * 8 + 80;
    for (int i = 0; i < lim && irq !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (irq !== 1'b1) begin
      errorCnt++;
      reportAndStop();
    end
    e = edgeCnt - e;
    chk(e + 1 >= n && e <= n + 1, 1'b1);
    rd(OWC_OFF_CTRL, d);
    chk(d[1], 1'b0);
    rd(OWC_OFF_STAT, d);
    chk(d, 32'h1);
    wr(OWC_OFF_STAT, 32'h1);
    chk(irq, 1'b0);
  endtask : warm

  initial begin
    logic [31:0] d, v;
    clk = 0;
    rst_n = 0;
    addr = 0;
    wrData = 0;
    wrEn = 0;
    rdEn = 0;
    srcNow = 0;
    prevSel = 0;
    pinCnt = 0;
    fastOscClk = 0;
    slowOscClk = 0;
    edgeCnt = 0;
    errorCnt = 0;
    nChecks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(OWC_OFF_CTRL, d);
    chk(d, 32'h0000_0310);
    chk({fastOscEnable, slowOscEnable, pllEnable, irq}, 4'b1100);
    // random control words without start, plus the all-ones corner
    for (int i = 0; i < 24; i++) begin
      // bits 13:12 are always written as zero by software
      v = (i == 0) ? 32'hFFFF_CFFE : $random(seed) & 32'hFFFF_CFFE;
      wr(OWC_OFF_CTRL, v);
      chk({pllEnable, fastOscEnable, slowOscEnable}, {v[2], v[8], v[9]});
      rd(OWC_OFF_CTRL, d);
      chk(d, v & 32'h0000_037C);
      // multiplied clock only picked while the pll runs
      v = $random(seed) & {31'h0000_0000, v[2]};
      wr(OWC_OFF_PLL_SOURCE_SELECT, v);
      chk(pllSourceSelect, v[0]);
      // deselect and confirm before the next write may stop the pll
      wr(OWC_OFF_PLL_SOURCE_SELECT, 32'h0000_0000);
      rd(OWC_OFF_PLL_SOURCE_SELECT, d);
      chk(d, 32'h0000_0000);
    end
    // unmapped place ignores writes and reads zero
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, d);
    chk(d, 32'h0);
    // pll shutdown in the required order
    wr(OWC_OFF_CTRL, 32'h0000_0304);
    wr(OWC_OFF_PLL_SOURCE_SELECT, 32'h1);
    chk({pllEnable, pllSourceSelect}, 2'b11);
    wr(OWC_OFF_PLL_SOURCE_SELECT, 32'h0);
    rd(OWC_OFF_PLL_SOURCE_SELECT, d);
    chk(d, 32'h0);
    wr(OWC_OFF_CTRL, 32'h0000_0300);
    chk(pllEnable, 1'b0);
    // masked completion stays silent but sticky
    wr(OWC_OFF_MASK, 32'h0);
    wr(OWC_OFF_CTRL, 32'h0000_0301);
    repeat (4) @(posedge clk);
    #1 chk(irq, 1'b0);
    rd(OWC_OFF_STAT, d);
    chk(d, 32'h1);
    wr(OWC_OFF_MASK, 32'h1);
    chk(irq, 1'b1);
    wr(OWC_OFF_STAT, 32'h1);
    // every code on both oscillators, one restart in mid-count
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 8; c++) begin
        warm(s[0], c[2:0], s == 0 && c == 4);
      end
    end
    // reset in mid-count returns all to reset values
    wr(OWC_OFF_CTRL, 32'h0000_0375);
    repeat (20) @(posedge clk);
    doReset();
    reportAndStop();
  end
endmodule : test_owc_osc_control
